// ===== src/mrz_dram_end.sv
// memory end: mode register zero, burst engine and dll timing
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - controller rewrites mode only while idle
// - mode set with bank zero writes register
// - controller zeroes reserved bank and address bits
// - write recovery programmed at least rounded minimum
// - write recovery plus precharge gives autoprecharge delay
// - bit three picks sequential or interleaved
// - two bits pick chop, full or per-command
// - full reads ordered by start column, type
// - chopped reads drive four beats, rest undriven
// - writes fill fixed order, chop uses column two
// - fixed chop starts write recovery two clocks early
// - per-command chop keeps full-burst write timing
// - cas latency field, whole cycles only
// - first read data at additive plus cas
// - controller keeps test mode bit zero
// - dll reset bit clears itself
// - wait dll lock before any read
// - controller issues dll reset after enabling
// - slow exit freezes dll, longer exit wait
// - fast exit keeps dll, short exit wait
// - mode set commands spaced by cycle time
// - every mode set carries the whole image
module mrz_dram_end #(
   parameter logic [15:0][4:0] CL_LUT = mrz_pkg::CL_LUT_DEF,
   parameter logic [7:0][4:0] WR_LUT = mrz_pkg::WR_LUT_DEF,
   parameter logic [3:0][1:0] BL_LUT = mrz_pkg::BL_LUT_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   mrz_link_if.dev link,
   output logic [1:0] burstMode_q,
   output logic interleave_q,
   output logic [4:0] casCycles_q,
   output logic [4:0] wrCycles_q,
   output logic [5:0] dalCycles_q,
   output logic testMode_q,
   output logic ppdFast_q,
   output logic dllReset_q,
   output logic dllLocked_q,
   output logic dllFrozen_q,
   output logic powerDown_q,
   output logic exitBusy_q,
   output logic recoveryBusy_q
);
   logic [7:0] mem [64];

   // command decode
   wire isMrs = link.cmdValid && link.cmdOp == mrz_pkg::OP_MRS;
   wire mrsHit = isMrs && link.bank == 3'h0;
   wire rdHit = link.cmdValid && link.cmdOp == mrz_pkg::OP_RD;
   wire wrHit = link.cmdValid && link.cmdOp == mrz_pkg::OP_WR;
   wire pdeHit = link.cmdValid && link.cmdOp == mrz_pkg::OP_PDE;
   wire pdxHit = link.cmdValid && link.cmdOp == mrz_pkg::OP_PDX;
   wire dllHit = mrsHit && link.addr[mrz_pkg::F_DLL];

   // new field values from the address pins
   wire [3:0] clCode = {link.addr[6:4], link.addr[2]};
   wire [4:0] clNew = CL_LUT[clCode];
   wire [4:0] wrNew = WR_LUT[link.addr[11:9]];
   wire [1:0] bmNew = BL_LUT[link.addr[1:0]];
   wire [5:0] dalNew = 6'({5'h00, wrNew} + mrz_pkg::TRP_CYC);

   // chop per command: fixed chop, or on-the-fly with bit 12 low
   wire isFixedChop = burstMode_q == mrz_pkg::BM_CHOP4;
   wire otfChop = burstMode_q == mrz_pkg::BM_OTF
      && !link.addr[mrz_pkg::F_OTF];
   wire chopNow = isFixedChop || otfChop;

   wire [5:0] readLat = {1'b0, casCycles_q} + {2'b00, link.addLatency};
   wire [5:0] writeLat = mrz_pkg::CWL_CYC + {2'b00, link.addLatency};

   // read engine
   logic [9:0] rdWait_q;
   logic rdPend_q;
   logic rdRun_q;
   logic rdChop_q;
   logic [2:0] rdBeat_q;
   logic [5:0] rdCol_q;
   logic [7:0] devDq_q;
   logic devDqOe_q;
   logic [9:0] rdWait_d;
   wire rdStart = rdPend_q && rdWait_q == 10'h000;
   wire rdEmit = rdStart || rdRun_q;
   wire [2:0] rdBeat = rdStart ? 3'h0 : rdBeat_q;
   wire [2:0] rdWord;
   // first word flop loads one cycle ahead, so wait is latency minus two
   assign rdWait_d = rdHit ? ({4'h0, readLat} - 10'h002)
      : (rdWait_q != 10'h000) ? rdWait_q - 10'h001 : 10'h000;
   // tail of a chopped read leaves the wire undriven
   wire rdDrive = rdEmit && !(rdChop_q && rdBeat[2]);

   mrz_burst_order u_order (
      .startCol(rdCol_q[2:0]),
      .interleave(interleave_q),
      .beat(rdBeat),
      .word(rdWord)
   );

   // write engine
   logic [9:0] wrWait_q;
   logic wrPend_q;
   logic wrRun_q;
   logic wrChop_q;
   logic wrFixed_q;
   logic wrAp_q;
   logic [2:0] wrBeat_q;
   logic [5:0] wrCol_q;
   logic [9:0] wrWait_d;
   wire wrStart = wrPend_q && wrWait_q == 10'h000;
   wire wrCap = wrStart || wrRun_q;
   wire [2:0] wrBeat = wrStart ? 3'h0 : wrBeat_q;
   assign wrWait_d = wrHit ? ({4'h0, writeLat} - 10'h001)
      : (wrWait_q != 10'h000) ? wrWait_q - 10'h001 : 10'h000;
   // full bursts ignore the low column bits; chops keep column bit 2
   wire [2:0] wrWord = wrChop_q ? {wrCol_q[2], wrBeat[1:0]}
      : wrBeat;
   wire wrKeep = wrCap && !(wrChop_q && wrBeat[2]);
   // fixed chop ends its internal write two beats before a full burst
   wire [2:0] wrLastBeat = wrFixed_q ? 3'h5 : 3'h7;
   wire recStart = wrCap && wrBeat == wrLastBeat;

   // recovery, dll lock and power-down exit counters
   logic [9:0] recCnt_q;
   logic [9:0] dllCnt_q;
   logic [9:0] exitCnt_q;
   logic [9:0] recCnt_d;
   logic [9:0] dllCnt_d;
   logic [9:0] exitCnt_d;
   wire [9:0] recLoad = wrAp_q ? {4'h0, dalCycles_q}
      : {5'h00, wrCycles_q};
   assign recCnt_d = recStart ? recLoad
      : (recCnt_q != 10'h000) ? recCnt_q - 10'h001 : 10'h000;
   assign dllCnt_d = dllReset_q ? mrz_pkg::DLL_LOCK_CYC
      : (dllCnt_q != 10'h000) ? dllCnt_q - 10'h001 : 10'h000;
   wire [9:0] exitLoad = ppdFast_q ? mrz_pkg::FAST_EXIT_CYC
      : mrz_pkg::SLOW_EXIT_CYC;
   assign exitCnt_d = pdxHit ? exitLoad
      : (exitCnt_q != 10'h000) ? exitCnt_q - 10'h001 : 10'h000;

   // mode register zero and status
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         burstMode_q <= mrz_pkg::BM_FULL8;
         interleave_q <= 1'b0;
         casCycles_q <= 5'h00;
         wrCycles_q <= 5'h00;
         dalCycles_q <= 6'h00;
         testMode_q <= 1'b0;
         ppdFast_q <= 1'b0;
      end else if (mrsHit) begin
         burstMode_q <= bmNew;
         interleave_q <= link.addr[mrz_pkg::F_BT];
         casCycles_q <= clNew;
         wrCycles_q <= wrNew;
         dalCycles_q <= dalNew;
         testMode_q <= link.addr[mrz_pkg::F_TM];
         ppdFast_q <= link.addr[mrz_pkg::F_PPD];
      end
   end

   // reset bit lives one cycle: set by the command, cleared as lock starts
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dllReset_q <= 1'b0;
         dllCnt_q <= 10'h000;
         dllLocked_q <= 1'b0;
      end else begin
         dllReset_q <= dllHit;
         dllCnt_q <= dllCnt_d;
         dllLocked_q <= !dllHit && !dllReset_q && dllCnt_d == 10'h000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         powerDown_q <= 1'b0;
         dllFrozen_q <= 1'b0;
         exitCnt_q <= 10'h000;
         exitBusy_q <= 1'b0;
         recCnt_q <= 10'h000;
         recoveryBusy_q <= 1'b0;
      end else begin
         if (pdeHit) begin
            powerDown_q <= 1'b1;
            dllFrozen_q <= !ppdFast_q;
         end else if (pdxHit) begin
            powerDown_q <= 1'b0;
            dllFrozen_q <= 1'b0;
         end
         exitCnt_q <= exitCnt_d;
         exitBusy_q <= exitCnt_d != 10'h000;
         recCnt_q <= recCnt_d;
         recoveryBusy_q <= recCnt_d != 10'h000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdWait_q <= 10'h000;
         rdPend_q <= 1'b0;
         rdRun_q <= 1'b0;
         rdBeat_q <= 3'h0;
         rdCol_q <= 6'h00;
         rdChop_q <= 1'b0;
         devDq_q <= 8'h00;
         devDqOe_q <= 1'b0;
      end else begin
         rdWait_q <= rdWait_d;
         if (rdHit) begin
            rdPend_q <= 1'b1;
            rdCol_q <= link.addr[5:0];
            rdChop_q <= chopNow;
         end else if (rdStart) begin
            rdPend_q <= 1'b0;
         end
         if (rdEmit) begin
            rdRun_q <= rdBeat != 3'h7;
            rdBeat_q <= rdBeat + 3'h1;
         end
         devDq_q <= rdDrive ? mem[{rdCol_q[5:3], rdWord}] : 8'h00;
         devDqOe_q <= rdDrive;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wrWait_q <= 10'h000;
         wrPend_q <= 1'b0;
         wrRun_q <= 1'b0;
         wrBeat_q <= 3'h0;
         wrCol_q <= 6'h00;
         wrChop_q <= 1'b0;
         wrFixed_q <= 1'b0;
         wrAp_q <= 1'b0;
      end else begin
         wrWait_q <= wrWait_d;
         if (wrHit) begin
            wrPend_q <= 1'b1;
            wrCol_q <= link.addr[5:0];
            wrChop_q <= chopNow;
            wrFixed_q <= isFixedChop;
            wrAp_q <= link.addr[mrz_pkg::F_AP];
         end else if (wrStart) begin
            wrPend_q <= 1'b0;
         end
         if (wrCap) begin
            wrRun_q <= wrBeat != 3'h7;
            wrBeat_q <= wrBeat + 3'h1;
         end
      end
   end

   // array has no reset; contents are undefined until written
   always_ff @(posedge clk_sys) begin
      if (wrKeep) begin
         mem[{wrCol_q[5:3], wrWord}] <= link.dq;
      end
   end

   assign link.devDq = devDq_q;
   assign link.devDqOe = devDqOe_q;
endmodule
`default_nettype wire

// ===== src/mrz_pkg.sv
// shared constants and types for the mode register zero link
`default_nettype none
package mrz_pkg;
   localparam int CLK_NS = 50;

   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_MRS = 3'h1,
      OP_RD = 3'h2,
      OP_WR = 3'h3,
      OP_PDE = 3'h4,
      OP_PDX = 3'h5
   } mrz_op_e;

   localparam logic [1:0] BM_FULL8 = 2'h0;
   localparam logic [1:0] BM_OTF = 2'h1;
   localparam logic [1:0] BM_CHOP4 = 2'h2;

   // field positions in the mode image and in read or write addresses
   localparam int F_BT = 3;
   localparam int F_TM = 7;
   localparam int F_DLL = 8;
   localparam int F_AP = 10;
   localparam int F_PPD = 12;
   localparam int F_OTF = 12;

   // times in ns, cycles derived (least times round up)
   localparam int TWR_NS = 15;
   localparam int TRP_NS = 15;
   localparam int TWTR_NS = 8;
   localparam int FAST_EXIT_NS = 25;
   localparam int SLOW_EXIT_NS = 100;
   localparam logic [9:0] WR_MIN_CYC = 10'((TWR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] TRP_CYC = 10'((TRP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] WTR_CYC = 10'((TWTR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] FAST_EXIT_CYC =
      10'((FAST_EXIT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] SLOW_EXIT_CYC =
      10'((SLOW_EXIT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] DLL_LOCK_CYC = 10'h200;
   localparam logic [9:0] MODE_SET_CYC = 10'h004;
   localparam logic [9:0] CHOP_PULL_CYC = 10'h002;
   localparam logic [5:0] CWL_CYC = 6'h05;
   localparam logic [9:0] BURST_CYC = 10'h008;

   // encoding tables, overridable per part
   localparam logic [15:0][4:0] CL_LUT_DEF = {
      5'h13, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c,
      5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
   localparam logic [7:0][4:0] WR_LUT_DEF = {
      5'h10, 5'h0e, 5'h0c, 5'h0a, 5'h08, 5'h07, 5'h06, 5'h05};
   localparam logic [3:0][1:0] BL_LUT_DEF = {
      BM_FULL8, BM_CHOP4, BM_OTF, BM_FULL8};
   localparam logic [2:0] WR_SAFE_CODE = 3'h7;

   // controller register byte offsets
   localparam logic [4:0] REG_MODE = 5'h00;
   localparam logic [4:0] REG_CMD = 5'h04;
   localparam logic [4:0] REG_WDLO = 5'h08;
   localparam logic [4:0] REG_WDHI = 5'h0c;
   localparam logic [4:0] REG_RDLO = 5'h10;
   localparam logic [4:0] REG_RDHI = 5'h14;
   localparam logic [4:0] REG_STAT = 5'h18;
   localparam logic [1:0] CMD_RD = 2'h0;
   localparam logic [1:0] CMD_WR = 2'h1;
   localparam logic [1:0] CMD_PDE = 2'h2;
   localparam logic [1:0] CMD_PDX = 2'h3;
   localparam logic [15:0] RST_MODE = 16'h0000;
endpackage
`default_nettype wire

// ===== src/mrz_link_if.sv
// command, address and data wires between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface mrz_link_if;
   logic cmdValid;
   logic [2:0] cmdOp;
   logic [2:0] bank;
   logic [15:0] addr;
   logic [3:0] addLatency;
   logic [7:0] ctrlDq;
   logic ctrlDqOe;
   logic [7:0] devDq;
   logic devDqOe;
   logic [7:0] dq;

   // resolved data wire; undriven reads as zero
   assign dq = devDqOe ? devDq : (ctrlDqOe ? ctrlDq : 8'h00);

   modport dev (
      input cmdValid, cmdOp, bank, addr, addLatency, dq,
      output devDq, devDqOe
   );
   modport ctrl (
      input dq, devDqOe,
      output cmdValid, cmdOp, bank, addr, addLatency, ctrlDq, ctrlDqOe
   );
endinterface
`default_nettype wire

// ===== src/mrz_burst_order.sv
// word index within an eight-word burst for a given beat
`timescale 1ns/1ps
`default_nettype none
module mrz_burst_order (
   input wire logic [2:0] startCol,
   input wire logic interleave,
   input wire logic [2:0] beat,
   output logic [2:0] word
);
   wire [1:0] seqLow = startCol[1:0] + beat[1:0];
   // sequential wraps inside a half, then crosses; interleaved is xor
   assign word = interleave ? (startCol ^ beat)
      : {startCol[2] ^ beat[2], seqLow};
endmodule
`default_nettype wire

// ===== src/mrz_ctrl_end.sv
// controller end: avalon registers driving mode sets and bursts
`timescale 1ns/1ps
`default_nettype none
module mrz_ctrl_end #(
   parameter logic [15:0][4:0] CL_LUT = mrz_pkg::CL_LUT_DEF,
   parameter logic [7:0][4:0] WR_LUT = mrz_pkg::WR_LUT_DEF,
   parameter logic [3:0][1:0] BL_LUT = mrz_pkg::BL_LUT_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   mrz_link_if.ctrl link,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest
);
   typedef enum logic [1:0] {CS_IDLE = 2'b01, CS_ACK = 2'b10} mrz_cst_e;
   mrz_cst_e state_q;
   logic [15:0] mode_q;
   logic [3:0] al_q;
   logic [9:0] cmd_q;
   logic [63:0] wdata_q;
   logic [63:0] rdata_q;
   wire [63:0] wdata_d;
   logic rdDone_q;
   logic pd_q;
   logic firstMrs_q;
   logic [9:0] hold_q;
   logic [9:0] dll_q;

   wire [4:0] off = {address[4:2], 2'b00};
   wire selMode = off == mrz_pkg::REG_MODE;
   wire selCmd = off == mrz_pkg::REG_CMD;
   wire [1:0] op = writedata[1:0];
   wire apIn = writedata[9];

   // decoded current settings
   wire [1:0] bm = BL_LUT[mode_q[1:0]];
   wire [4:0] cas = CL_LUT[{mode_q[6:4], mode_q[2]}];
   wire [4:0] wrc = WR_LUT[mode_q[11:9]];
   wire [5:0] readLat = {1'b0, cas} + {2'b00, al_q};
   wire [5:0] writeLat = mrz_pkg::CWL_CYC + {2'b00, al_q};

   // sanitised image: reserved and test bits zero, recovery clamped
   wire [2:0] wrIn = writedata[11:9];
   wire wrLow = {5'h00, WR_LUT[wrIn]} < mrz_pkg::WR_MIN_CYC;
   wire [2:0] wrFix = wrLow ? mrz_pkg::WR_SAFE_CODE : wrIn;
   wire dllBit = writedata[8] || firstMrs_q;
   wire [15:0] mrsImg = {3'h0, writedata[12], wrFix, dllBit,
      1'b0, writedata[6:0]};
   wire [15:0] cmdAddr = {3'h0, writedata[8], 1'b0, apIn, 4'h0,
      writedata[7:2]};

   // idle means no burst, recovery or exit wait left, and awake
   wire idle = hold_q == 10'h000 && !pd_q;
   logic cmdOk;
   always_comb begin
      unique case (op)
         mrz_pkg::CMD_RD: cmdOk = idle && dll_q == 10'h000;
         mrz_pkg::CMD_WR: cmdOk = idle;
         mrz_pkg::CMD_PDE: cmdOk = idle;
         mrz_pkg::CMD_PDX: cmdOk = pd_q;
      endcase
   end
   // a blocked mode or command write simply holds waitrequest
   wire stall = write && ((selMode && !idle) || (selCmd && !cmdOk));
   wire go = state_q == CS_IDLE && (read || write) && !stall;
   wire issueMrs = go && write && selMode;
   wire issueCmd = go && write && selCmd;

   wire [9:0] rdHold = {4'h0, readLat} + mrz_pkg::BURST_CYC;
   wire [9:0] recHold = apIn ? ({5'h00, wrc} + mrz_pkg::TRP_CYC)
      : mrz_pkg::WTR_CYC;
   // fixed chop pulls recovery in; per-command chop does not
   wire [9:0] pull = (bm == mrz_pkg::BM_CHOP4) ? mrz_pkg::CHOP_PULL_CYC
      : 10'h000;
   wire [9:0] wrHold = {4'h0, writeLat} + mrz_pkg::BURST_CYC + recHold - pull;
   wire [9:0] exitHold = mode_q[mrz_pkg::F_PPD]
      ? mrz_pkg::FAST_EXIT_CYC : mrz_pkg::SLOW_EXIT_CYC;
   wire [9:0] cmdHold = (op == mrz_pkg::CMD_RD) ? rdHold
      : (op == mrz_pkg::CMD_WR) ? wrHold
      : (op == mrz_pkg::CMD_PDX) ? exitHold : 10'h001;
   wire [9:0] hold_d = issueMrs ? mrz_pkg::MODE_SET_CYC
      : issueCmd ? cmdHold
      : (hold_q != 10'h000) ? hold_q - 10'h001 : 10'h000;
   wire [9:0] dll_d = (issueMrs && dllBit) ? mrz_pkg::DLL_LOCK_CYC
      : (dll_q != 10'h000) ? dll_q - 10'h001 : 10'h000;
   wire [2:0] opCode = (op == mrz_pkg::CMD_RD) ? mrz_pkg::OP_RD
      : (op == mrz_pkg::CMD_WR) ? mrz_pkg::OP_WR
      : (op == mrz_pkg::CMD_PDE) ? mrz_pkg::OP_PDE : mrz_pkg::OP_PDX;

   // write data lanes with byte enables
   wire wdLoHit = go && write && off == mrz_pkg::REG_WDLO;
   wire wdHiHit = go && write && off == mrz_pkg::REG_WDHI;
   for (genvar i = 0; i < 8; i++) begin : g_lane
      wire hit = (i < 4) ? wdLoHit : wdHiHit;
      assign wdata_d[8*i +: 8] = (hit && byteenable[i % 4])
         ? writedata[8*(i % 4) +: 8] : wdata_q[8*i +: 8];
   end

   wire [31:0] rdMux = selMode ? {12'h000, al_q, mode_q}
      : selCmd ? {22'h000000, cmd_q}
      : (off == mrz_pkg::REG_WDLO) ? wdata_q[31:0]
      : (off == mrz_pkg::REG_WDHI) ? wdata_q[63:32]
      : (off == mrz_pkg::REG_RDLO) ? rdata_q[31:0]
      : (off == mrz_pkg::REG_RDHI) ? rdata_q[63:32]
      : (off == mrz_pkg::REG_STAT) ? {28'h0000000, rdDone_q,
         hold_q != 10'h000, dll_q != 10'h000, pd_q}
      : 32'h00000000;

   // data movers, timed from the issue edge
   logic [9:0] rdWait_q;
   logic [9:0] wrWait_q;
   logic rdPend_q;
   logic rdRun_q;
   logic wrPend_q;
   logic wrRun_q;
   logic [2:0] rdBeat_q;
   logic [2:0] wrBeat_q;
   wire isRd = issueCmd && op == mrz_pkg::CMD_RD;
   wire isWr = issueCmd && op == mrz_pkg::CMD_WR;
   wire rdStart = rdPend_q && rdWait_q == 10'h000;
   wire rdCap = rdStart || rdRun_q;
   wire [2:0] rdBeat = rdStart ? 3'h0 : rdBeat_q;
   wire wrStart = wrPend_q && wrWait_q == 10'h000;
   wire wrEmit = wrStart || wrRun_q;
   wire [2:0] wrBeat = wrStart ? 3'h0 : wrBeat_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= CS_IDLE;
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
         mode_q <= mrz_pkg::RST_MODE;
         al_q <= 4'h0;
         cmd_q <= 10'h000;
         pd_q <= 1'b0;
         firstMrs_q <= 1'b1;
         link.cmdValid <= 1'b0;
         link.cmdOp <= mrz_pkg::OP_NOP;
         link.bank <= 3'h0;
         link.addr <= 16'h0000;
      end else begin
         state_q <= go ? CS_ACK : CS_IDLE;
         waitrequest <= !go;
         if (go) begin
            readdata <= rdMux;
         end
         link.cmdValid <= issueMrs || issueCmd;
         link.cmdOp <= issueMrs ? mrz_pkg::OP_MRS : opCode;
         link.bank <= 3'h0;
         if (issueMrs) begin
            mode_q <= mrsImg;
            al_q <= writedata[19:16];
            firstMrs_q <= 1'b0;
            link.addr <= mrsImg;
         end else if (issueCmd) begin
            cmd_q <= writedata[9:0];
            link.addr <= cmdAddr;
            if (op == mrz_pkg::CMD_PDE) begin
               pd_q <= 1'b1;
            end else if (op == mrz_pkg::CMD_PDX) begin
               pd_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hold_q <= 10'h000;
         dll_q <= 10'h000;
         wdata_q <= 64'h0000000000000000;
         rdata_q <= 64'h0000000000000000;
         rdDone_q <= 1'b0;
         rdWait_q <= 10'h000;
         wrWait_q <= 10'h000;
         {rdPend_q, rdRun_q, wrPend_q, wrRun_q} <= 4'h0;
         rdBeat_q <= 3'h0;
         wrBeat_q <= 3'h0;
         link.ctrlDq <= 8'h00;
         link.ctrlDqOe <= 1'b0;
      end else begin
         hold_q <= hold_d;
         dll_q <= dll_d;
         wdata_q <= wdata_d;
         rdWait_q <= isRd ? {4'h0, readLat}
            : (rdWait_q != 10'h000) ? rdWait_q - 10'h001 : 10'h000;
         wrWait_q <= isWr ? ({4'h0, writeLat} - 10'h001)
            : (wrWait_q != 10'h000) ? wrWait_q - 10'h001 : 10'h000;
         rdPend_q <= isRd || (rdPend_q && !rdStart);
         wrPend_q <= isWr || (wrPend_q && !wrStart);
         if (isRd) begin
            rdDone_q <= 1'b0;
         end
         if (rdCap) begin
            rdRun_q <= rdBeat != 3'h7;
            rdBeat_q <= rdBeat + 3'h1;
            rdDone_q <= rdBeat == 3'h7;
            if (link.devDqOe) begin
               rdata_q[{rdBeat, 3'h0} +: 8] <= link.dq;
            end
         end
         if (wrEmit) begin
            wrRun_q <= wrBeat != 3'h7;
            wrBeat_q <= wrBeat + 3'h1;
         end
         link.ctrlDq <= wrEmit ? wdata_q[{wrBeat, 3'h0} +: 8] : 8'h00;
         link.ctrlDqOe <= wrEmit;
      end
   end

   assign link.addLatency = al_q;
endmodule
`default_nettype wire

// ===== sim/mrz_link_properties.sv
// link checker for the mode register zero link
`timescale 1ns/1ps
`default_nettype none
module mrz_link_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cmdValid,
   input wire logic [2:0] cmdOp,
   input wire logic [2:0] bank,
   input wire logic [15:0] addr,
   input wire logic [3:0] addLatency,
   input wire logic ctrlDqOe,
   input wire logic devDqOe
);
   logic [4:0] cl_q;
   logic [1:0] bm_q;
   logic chop_q;
   logic rd_q;
   logic [9:0] lat_q;
   logic [9:0] dll_q;
   wire logic mrs = cmdValid && cmdOp == mrz_pkg::OP_MRS;
   wire logic rdc = cmdValid && cmdOp == mrz_pkg::OP_RD;
   wire logic wrc = cmdValid && cmdOp == mrz_pkg::OP_WR;
   wire logic otfChop = bm_q == mrz_pkg::BM_OTF && !addr[12];
   // latency is tracked from the last image, so a skipped image shows up
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lat_q <= 10'h000;
         dll_q <= 10'h000;
      end else begin
         if (mrs) cl_q <= mrz_pkg::CL_LUT_DEF[{addr[6:4], addr[2]}];
         if (mrs) bm_q <= mrz_pkg::BL_LUT_DEF[addr[1:0]];
         if (rdc) chop_q <= bm_q == mrz_pkg::BM_CHOP4 || otfChop;
         if (rdc || wrc) rd_q <= rdc;
         if (rdc) lat_q <= 10'(addLatency) + 10'(cl_q);
         else if (wrc) lat_q <= 10'(addLatency) + 10'(mrz_pkg::CWL_CYC);
         else if (lat_q != 10'h000) lat_q <= lat_q - 10'h001;
         if (mrs && addr[8]) dll_q <= mrz_pkg::DLL_LOCK_CYC;
         else if (dll_q != 10'h000) dll_q <= dll_q - 10'h001;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence beats4;
      devDqOe [*4] ##1 !devDqOe;
   endsequence
   sequence beats8(logic s);
      s [*8] ##1 !s;
   endsequence
   bank_zero_a: assert property (cmdValid |-> bank == 3'h0)
      else $error("command with nonzero bank");
   rsvd_bits_a: assert property (mrs |-> addr[15:13] == 3'h0)
      else $error("reserved mode bits set");
   test_off_a: assert property (mrs |-> !addr[7])
      else $error("test mode bit set");
   mrs_gap_a: assert property (mrs |=> !mrs [*3])
      else $error("mode sets too close");
   dll_wait_a: assert property (rdc |-> dll_q <= 10'h001)
      else $error("read before dll lock");
   first_beat_a: assert property (lat_q == 10'h001 |->
      $rose(rd_q ? devDqOe : ctrlDqOe))
      else $error("first beat at wrong cycle");
   chop_read_a: assert property (
      $rose(devDqOe) && chop_q |-> beats4)
      else $error("chopped read not four beats");
   full_read_a: assert property ($rose(devDqOe) && !chop_q |->
      beats8(devDqOe))
      else $error("full read not eight beats");
   write_len_a: assert property (
      $rose(ctrlDqOe) |-> beats8(ctrlDqOe))
      else $error("write burst not eight beats");
   one_driver_a: assert property (!(devDqOe && ctrlDqOe))
      else $error("both ends drive data");
endmodule
`default_nettype wire

// ===== sim/tb.sv
// bench: both link ends driven through the avalon registers
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic [1:0] burstMode_q;
   logic [4:0] casCycles_q, wrCycles_q;
   logic [5:0] dalCycles_q;
   logic interleave_q, testMode_q, ppdFast_q, dllReset_q;
   logic dllFrozen_q, powerDown_q, chop;
   logic dllLocked_q, exitBusy_q, recoveryBusy_q;
   logic [31:0] rd, m, elo, ehi;
   logic [63:0] d;
   logic [2:0] w, src;
   logic [1:0] bl;
   int n_mismatch = 0;
   int num_checks = 0;
   int seed = 53;
   mrz_link_if lnk();
   always #25 clk_sys = ~clk_sys;
   mrz_link_properties i_mrz_link_properties (.clk_sys(clk_sys), .rst(rst),
      .cmdValid(lnk.cmdValid), .cmdOp(lnk.cmdOp), .bank(lnk.bank),
      .addr(lnk.addr), .addLatency(lnk.addLatency),
      .ctrlDqOe(lnk.ctrlDqOe), .devDqOe(lnk.devDqOe));
   mrz_dram_end i_mrz_dram_end (.clk_sys(clk_sys), .rst(rst), .link(lnk),
      .burstMode_q(burstMode_q), .interleave_q(interleave_q),
      .casCycles_q(casCycles_q), .wrCycles_q(wrCycles_q),
      .dalCycles_q(dalCycles_q), .testMode_q(testMode_q),
      .ppdFast_q(ppdFast_q), .dllReset_q(dllReset_q),
      .dllLocked_q(dllLocked_q), .dllFrozen_q(dllFrozen_q),
      .powerDown_q(powerDown_q), .exitBusy_q(exitBusy_q),
      .recoveryBusy_q(recoveryBusy_q));
   mrz_ctrl_end i_mrz_ctrl_end (.clk_sys(clk_sys), .rst(rst), .link(lnk),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest));
   task automatic give_verdict();
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // long bound: a read may stall for the whole dll lock count
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] dat);
      int i;
      @(posedge clk_sys);
      address <= a;
      writedata <= dat;
      read <= !wr;
      write <= wr;
      for (i = 0; i < 2000 && waitrequest !== 1'b0; i++) @(posedge clk_sys);
      if (i == 2000) n_mismatch++;
      if (i == 2000) give_verdict();
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   function automatic logic [2:0] ord(input logic [2:0] c, input logic il,
      input logic [2:0] b);
      ord = il ? b ^ c : {b[2] ^ c[2], c[1:0] + b[1:0]};
   endfunction
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b0, mrz_pkg::REG_STAT, 32'h00000000);
      chk(rd, 32'h00000000);
      for (int k = 0; k < 12; k++) begin
         bl = 2'(k % 3);
         m = $random(seed);
         bus(1'b1, mrz_pkg::REG_MODE,
            {12'h000, m[19:16], 3'h0, m[12:9], 2'h0, m[6:2], bl});
         @(posedge clk_sys);
         chk(dllReset_q, k == 0);
         repeat (2) @(posedge clk_sys);
         chk(burstMode_q, mrz_pkg::BL_LUT_DEF[bl]);
         chk(interleave_q, m[3]);
         chk(casCycles_q, mrz_pkg::CL_LUT_DEF[{m[6:4], m[2]}]);
         elo = mrz_pkg::WR_LUT_DEF[m[11:9]];
         chk(wrCycles_q, elo);
         chk(dalCycles_q, elo + mrz_pkg::TRP_CYC);
         chk(ppdFast_q, m[12]);
         chk({testMode_q, dllReset_q}, 32'h00000000);
         chk(dllLocked_q, k != 0);
         d = {$random(seed), $random(seed)};
         bus(1'b1, mrz_pkg::REG_WDLO, d[31:0]);
         bus(1'b1, mrz_pkg::REG_WDHI, d[63:32]);
         bus(1'b1, mrz_pkg::REG_CMD, {23'h0, m[28:22], mrz_pkg::CMD_WR});
         bus(1'b1, mrz_pkg::REG_CMD, {23'h0, m[28:22], mrz_pkg::CMD_RD});
         chop = bl == 2'h2 || (bl == 2'h1 && !m[28]);
         for (int b = 0; b < 8; b++) begin
            w = ord(m[24:22], m[3], 3'(b));
            src = chop ? {1'b0, w[1:0]} : w;
            if (b < 4) elo[8*b +: 8] = d[8*src +: 8];
            else if (!chop) ehi[8*(b-4) +: 8] = d[8*src +: 8];
         end
         bus(1'b1, mrz_pkg::REG_CMD, {30'h0, mrz_pkg::CMD_PDE});
         repeat (2) @(posedge clk_sys);
         chk({recoveryBusy_q, powerDown_q, dllFrozen_q},
            {30'h1, !m[12]});
         bus(1'b1, mrz_pkg::REG_CMD, {30'h0, mrz_pkg::CMD_PDX});
         repeat (2) @(posedge clk_sys);
         chk(exitBusy_q, !m[12]);
         bus(1'b0, mrz_pkg::REG_RDLO, 32'h00000000);
         chk(rd, elo);
         bus(1'b0, mrz_pkg::REG_RDHI, 32'h00000000);
         chk(rd, ehi);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
